// ### shared/psram_pkg.sv
/*
  Shared constants, state encoding and address helpers for the PSRAM link
  device. Assumes a host that drives chip select, the link clock and the
  command/address bytes, and a system clock domain that sets the config pins.
*/
// Overview of operation
// - register reads send Word[15:8] while strobe high, Word[7:0] while low
// - register writes capture Word[15:8] on rising, Word[7:0] on falling edge
// - after latency, host strobe acts as per-byte write mask
// - masked byte (strobe high) leaves array; strobe low stores byte
// - zero-latency writes store full words; device releases strobe
// - first three clock cycles carry three 16-bit command/address words
// - command/address bit 47 high means read, low means write
// - bit 46 low selects memory array, high selects register space
// - bit 45 selects wrapped or linear burst
// - array access may start once bits 47..16 are captured
// - third command/address word gives target word address in row
// - read data withheld until configured latency cycles complete
// - strobe during command phase flags single or doubled latency
// - after latency strobe toggles with each edge-aligned data byte
// - read data continues while clock toggles with chip select low
// - wrapped burst wraps in burst length; linear runs sequentially
// - linear burst past last address continues at first address
// - chip select high ends the read; device stops driving data
// - no dependence on a free-running link clock; config pin changes still need two link clock edges to pass the synchroniser
// - device drives strobe during read transactions
package psram_pkg;

  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int CA_W = 48;
  localparam int LAT_W = 4;
  localparam int BURST_W = 2;
  localparam int CYC_W = 8;
  localparam int ROW_W = 5;
  localparam int COL_W = 3;
  localparam int ADDR_W = ROW_W + COL_W;
  localparam int DEPTH = 256;

  // command/address field positions
  localparam int CA_READ_BIT = 47;
  localparam int CA_REG_BIT = 46;
  localparam int CA_LINEAR_BIT = 45;
  localparam int REG_INDEX_BIT = 0;

  // link cycle indices, counted in rising link clock edges from chip select low
  localparam logic [CYC_W-1:0] CYC_FIRST = 8'h00;
  localparam logic [CYC_W-1:0] CYC_ROW = 8'h02;
  localparam logic [CYC_W-1:0] CYC_CA_DONE = 8'h03;
  localparam logic [CYC_W-1:0] CYC_REG_DATA = 8'h04;
  localparam logic [CYC_W-1:0] CYC_MAX = 8'hFF;

  // reset values
  localparam logic [CA_W-1:0] CA_RESET = 48'h0000_0000_0000;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
  localparam logic [LAT_W-1:0] LAT_MIN = 4'h1;

  // identification word, value is arbitrary
  localparam logic [WORD_W-1:0] REG_ID_WORD = 16'h5A3C;

  typedef enum logic [4:0] {
    ST_CMD = 5'b00001,
    ST_LAT = 5'b00010,
    ST_READ = 5'b00100,
    ST_WRITE = 5'b01000,
    ST_HOLD = 5'b10000
  } link_state_t;

  // word-address mask of a wrapped burst: 8, 16, 32 or 64 words
  function automatic logic [ADDR_W-1:0] burst_mask(input logic [BURST_W-1:0] code);
    case (code)
      2'h0: burst_mask = 8'h07;
      2'h1: burst_mask = 8'h0F;
      2'h2: burst_mask = 8'h1F;
      default: burst_mask = 8'h3F;
    endcase
  endfunction : burst_mask

  function automatic logic [ADDR_W-1:0] wrap_next(input logic [ADDR_W-1:0] addr,
                                                  input logic linear,
                                                  input logic [BURST_W-1:0] code);
    logic [ADDR_W-1:0] m;
    logic [ADDR_W-1:0] inc;
    m = burst_mask(code);
    inc = addr + 8'h01;
    if (linear) begin
      wrap_next = inc;
    end else begin
      wrap_next = (addr & ~m) | (inc & m);
    end
  endfunction : wrap_next

endpackage : psram_pkg

// ### verilog/bit_sync.sv
/*
  Two-flop level synchroniser for quasi-static or toggle signals.
  Assumes the source changes slowly compared with the destination clock.
*/
module bit_sync #(
  parameter int WIDTH = 1
) (
  // destination clock
  input wire logic clk_in,
  // asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] meta;

  // first stage is read only by the second
  always_ff @(posedge clk_in) begin
    meta <= level_in;
    level_out <= meta;
  end

endmodule : bit_sync

// ### verilog/psram_link_dev.sv
/*
  Device side of an 8-bit DDR PSRAM link: command/address decode, latency,
  strobe-aligned reads, masked writes, burst wrap and a small flip-flop array.
  Assumes the host owns the link clock and chip select; config pins come from
  logic on MCLK_IN and change only between transactions.
*/
module psram_link_dev (
  // system clock and reset
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  // link from the host
  input wire logic LINK_CK_IN,
  input wire logic CS_N_IN,
  input wire logic [psram_pkg::DATA_W-1:0] DQ_IN,
  output logic [psram_pkg::DATA_W-1:0] DQ_OUT,
  output logic DQ_OE_N_OUT,
  input wire logic READ_WRITE_STROBE_IN,
  output logic READ_WRITE_STROBE_OUT,
  output logic READ_WRITE_STROBE_OE_N_OUT,
  // configuration
  input wire logic [psram_pkg::LAT_W-1:0] LATENCY_COUNT_IN,
  input wire logic [psram_pkg::BURST_W-1:0] BURST_LENGTH_IN,
  input wire logic EXTRA_LATENCY_IN,
  // status
  output logic BUSY_OUT,
  output logic [psram_pkg::WORD_W-1:0] REG_WRITE_DATA_OUT,
  output logic REG_WRITE_STROBE_OUT
);
  import psram_pkg::*;

  localparam int CFG_W = LAT_W + BURST_W + 1;

  // configuration seen by the link domain
  logic [CFG_W-1:0] cfg_sync;
  logic [LAT_W-1:0] lat_cfg;
  logic [BURST_W-1:0] burst_cfg;
  logic extra_cfg;

  // link rising-edge state
  logic [DATA_W-1:0] pos_byte;
  logic pos_mask;
  logic [CYC_W-1:0] cyc;
  logic [CA_W-1:0] ca;
  logic [CA_W-1:0] ca_next;
  logic [ROW_W-1:0] row;
  logic is_read;
  logic reg_space;
  logic linear;
  logic extra_lat;
  logic [CYC_W-1:0] data_start;
  link_state_t state;
  link_state_t next_state;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] cur_addr;
  logic [WORD_W-1:0] rd_word;
  logic [WORD_W-1:0] cfg_word;
  logic read_flag;
  logic dq_oe_n;
  logic strobe_oe_n;

  // link falling-edge state
  logic [DATA_W-1:0] neg_byte;
  logic [WORD_W-1:0] mem [DEPTH];
  logic [WORD_W-1:0] reg_wr_word;
  logic reg_wr_toggle;

  // system-domain state
  logic [1:0] sys_sync;
  logic tog_prev;

  bit_sync #(
    .WIDTH(CFG_W)
  ) u_cfg_sync (
    .clk_in(LINK_CK_IN),
    .level_in({LATENCY_COUNT_IN, BURST_LENGTH_IN, EXTRA_LATENCY_IN}),
    .level_out(cfg_sync)
  );

  assign lat_cfg = cfg_sync[CFG_W-1 -: LAT_W];
  assign burst_cfg = cfg_sync[1 +: BURST_W];
  assign extra_cfg = cfg_sync[0];

  // command/address word completes one rising edge after its falling byte
  assign ca_next = {ca[CA_W-WORD_W-1:0], pos_byte, neg_byte};
  assign cfg_word = {lat_cfg, burst_cfg, extra_cfg, 9'h000};
  assign read_flag = (cyc == CYC_CA_DONE) ? ca_next[CA_READ_BIT] : is_read;

  // raw bytes of every rising edge; data regs need no reset
  always_ff @(posedge LINK_CK_IN) begin
    pos_byte <= DQ_IN;
    pos_mask <= READ_WRITE_STROBE_IN;
  end

  // cycle count per frame
  // chip select high is the frame reset, since the clock may be stopped
  always_ff @(posedge LINK_CK_IN or posedge CS_N_IN) begin
    if (CS_N_IN) begin
      cyc <= CYC_FIRST;
    end else if (cyc != CYC_MAX) begin
      cyc <= cyc + 8'h01;
    end
  end

  always_ff @(posedge LINK_CK_IN or posedge CS_N_IN) begin
    if (CS_N_IN) begin
      ca <= CA_RESET;
      is_read <= 1'b0;
      reg_space <= 1'b0;
      linear <= 1'b0;
    end else if (cyc != CYC_FIRST && cyc <= CYC_CA_DONE) begin
      ca <= ca_next;
      if (cyc == CYC_CA_DONE) begin
        is_read <= ca_next[CA_READ_BIT];
        reg_space <= ca_next[CA_REG_BIT];
        linear <= ca_next[CA_LINEAR_BIT];
      end
    end
  end

  // latency flag sampled
  // latency is fixed at the first edge so it cannot shift mid-frame
  always_ff @(posedge LINK_CK_IN or posedge CS_N_IN) begin
    if (CS_N_IN) begin
      extra_lat <= 1'b0;
      data_start <= CYC_MAX;
    end else if (cyc == CYC_FIRST) begin
      extra_lat <= extra_cfg;
      if (lat_cfg < LAT_MIN) begin
        data_start <= CYC_CA_DONE + (extra_cfg ? {3'h0, LAT_MIN, 1'b0} : {4'h0, LAT_MIN});
      end else if (extra_cfg) begin
        data_start <= CYC_CA_DONE + {3'h0, lat_cfg, 1'b0};
      end else begin
        data_start <= CYC_CA_DONE + {4'h0, lat_cfg};
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_CMD: begin
        if (cyc == CYC_CA_DONE) begin
          if (!ca_next[CA_READ_BIT] && ca_next[CA_REG_BIT]) begin
            next_state = ST_HOLD;
          end else begin
            next_state = ST_LAT;
          end
        end
      end
      ST_LAT: begin
        if (cyc == data_start) begin
          next_state = is_read ? ST_READ : ST_WRITE;
        end
      end
      ST_READ: next_state = ST_READ;
      ST_WRITE: next_state = ST_WRITE;
      ST_HOLD: next_state = ST_HOLD;
      default: next_state = ST_CMD;
    endcase
  end

  always_ff @(posedge LINK_CK_IN or posedge CS_N_IN) begin
    if (CS_N_IN) begin
      state <= ST_CMD;
    end else begin
      state <= next_state;
    end
  end

  assign cur_addr = (state == ST_LAT) ? addr : wrap_next(addr, linear, burst_cfg);

  always_ff @(posedge LINK_CK_IN or posedge CS_N_IN) begin
    if (CS_N_IN) begin
      row <= {ROW_W{1'b0}};
      addr <= ADDR_RESET;
      rd_word <= WORD_RESET;
    end else begin
      if (cyc == CYC_ROW) begin
        row <= ca_next[ROW_W-1:0];
      end
      if (cyc == CYC_CA_DONE) begin
        addr <= {row, ca_next[COL_W-1:0]};
      end else if (next_state == ST_READ || next_state == ST_WRITE) begin
        addr <= cur_addr;
        if (!reg_space) begin
          rd_word <= mem[cur_addr];
        end else if (cur_addr[REG_INDEX_BIT]) begin
          rd_word <= REG_ID_WORD;
        end else begin
          rd_word <= cfg_word;
        end
      end
    end
  end

  always_ff @(posedge LINK_CK_IN or posedge CS_N_IN) begin
    if (CS_N_IN) begin
      dq_oe_n <= 1'b1;
      strobe_oe_n <= 1'b1;
    end else begin
      dq_oe_n <= (next_state != ST_READ);
      strobe_oe_n <= !(next_state == ST_CMD || next_state == ST_READ ||
                       (next_state == ST_LAT && read_flag));
    end
  end

  assign DQ_OE_N_OUT = dq_oe_n;
  assign READ_WRITE_STROBE_OE_N_OUT = strobe_oe_n;
  // byte follows each edge
  // double-rate output has to follow the clock level itself
  assign DQ_OUT = LINK_CK_IN ? rd_word[WORD_W-1:DATA_W] : rd_word[DATA_W-1:0];
  assign READ_WRITE_STROBE_OUT = (state == ST_READ) ? LINK_CK_IN : extra_lat;

  always_ff @(negedge LINK_CK_IN) begin
    neg_byte <= DQ_IN;
  end

  // mask applies on latency writes
  // array is written on the falling edge so the last word lands before the clock stops
  always_ff @(negedge LINK_CK_IN) begin
    if (state == ST_WRITE && !CS_N_IN && !reg_space) begin
      if (!pos_mask) begin
        mem[addr][WORD_W-1:DATA_W] <= pos_byte;
      end
      if (!READ_WRITE_STROBE_IN) begin
        mem[addr][DATA_W-1:0] <= DQ_IN;
      end
    end
  end

  // upper byte first
  // only the first word of a register write is kept
  always_ff @(negedge LINK_CK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      reg_wr_word <= WORD_RESET;
      reg_wr_toggle <= 1'b0;
    end else if (state == ST_HOLD && cyc == CYC_REG_DATA && !CS_N_IN) begin
      reg_wr_word <= {pos_byte, DQ_IN};
      reg_wr_toggle <= ~reg_wr_toggle;
    end
  end

  bit_sync #(
    .WIDTH(2)
  ) u_sys_sync (
    .clk_in(MCLK_IN),
    .level_in({CS_N_IN, reg_wr_toggle}),
    .level_out(sys_sync)
  );

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      BUSY_OUT <= 1'b0;
    end else begin
      BUSY_OUT <= !sys_sync[1];
    end
  end

  // word is stable long before its toggle clears the synchroniser
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      tog_prev <= 1'b0;
      REG_WRITE_STROBE_OUT <= 1'b0;
      REG_WRITE_DATA_OUT <= WORD_RESET;
    end else begin
      tog_prev <= sys_sync[0];
      REG_WRITE_STROBE_OUT <= sys_sync[0] ^ tog_prev;
      if (sys_sync[0] ^ tog_prev) begin
        REG_WRITE_DATA_OUT <= reg_wr_word;
      end
    end
  end

endmodule : psram_link_dev

// ### test/psram_link_monitor.sv
/* link assertions on the device ports; bound to the device top.
   assumes config pins stay still while chip select is low */
module psram_link_monitor (
  // clocks and resets
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic LINK_CK_IN,
  input wire logic CS_N_IN,
  // link and config
  input wire logic [psram_pkg::DATA_W-1:0] DQ_IN,
  input wire logic DQ_OE_N_OUT,
  input wire logic READ_WRITE_STROBE_OUT,
  input wire logic READ_WRITE_STROBE_OE_N_OUT,
  input wire logic [psram_pkg::LAT_W-1:0] LATENCY_COUNT_IN,
  input wire logic EXTRA_LATENCY_IN,
  // status
  input wire logic BUSY_OUT,
  input wire logic REG_WRITE_STROBE_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  import psram_pkg::*;
  logic [7:0] cnt;
  logic rd_req;
  logic [7:0] d_edge;
  // rising link edges since select, cleared by chip select
  always_ff @(posedge LINK_CK_IN or posedge CS_N_IN) begin
    if (CS_N_IN) begin
      cnt <= 8'h00;
    end else if (cnt != 8'hFF) begin
      cnt <= cnt + 8'h01;
    end
  end
  always_ff @(posedge LINK_CK_IN) begin
    if (cnt == 8'h00) begin
      rd_req <= DQ_IN[7];
    end
  end
  // zero latency counts as one
  assign d_edge = 8'h03 + ((LATENCY_COUNT_IN == 4'h0 ? 8'h01 : {4'h0, LATENCY_COUNT_IN})
                  << EXTRA_LATENCY_IN);
  sequence s_cs_held;
    !CS_N_IN [*4];
  endsequence
  sequence s_read_start;
    $fell(DQ_OE_N_OUT);
  endsequence
  property p_released;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      CS_N_IN && $past(CS_N_IN) |-> DQ_OE_N_OUT && READ_WRITE_STROBE_OE_N_OUT;
  endproperty
  a_released: assert property (p_released) else $error("lines driven while idle");
  property p_cmd_strobe;
    @(posedge LINK_CK_IN) disable iff (CS_N_IN)
      (cnt == 8'h01 || cnt == 8'h02) |->
      !READ_WRITE_STROBE_OE_N_OUT && READ_WRITE_STROBE_OUT == EXTRA_LATENCY_IN;
  endproperty
  a_cmd_strobe: assert property (p_cmd_strobe) else $error("bad latency flag");
  property p_read_strobe;
    @(negedge LINK_CK_IN) disable iff (CS_N_IN)
      !DQ_OE_N_OUT |-> READ_WRITE_STROBE_OUT && !READ_WRITE_STROBE_OE_N_OUT;
  endproperty
  a_read_strobe: assert property (p_read_strobe) else $error("strobe not clock");
  property p_latency;
    @(posedge LINK_CK_IN) disable iff (CS_N_IN) s_read_start |-> cnt == d_edge + 8'h01;
  endproperty
  a_latency: assert property (p_latency) else $error("read data early or late");
  property p_read_due;
    @(posedge LINK_CK_IN) disable iff (CS_N_IN)
      rd_req && cnt == d_edge + 8'h01 |-> !DQ_OE_N_OUT;
  endproperty
  a_read_due: assert property (p_read_due) else $error("read data missing");
  property p_write_quiet;
    @(posedge LINK_CK_IN) disable iff (CS_N_IN)
      !rd_req && cnt >= 8'h05 |-> DQ_OE_N_OUT && READ_WRITE_STROBE_OE_N_OUT;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("driven in write");
  property p_reg_pulse;
    @(posedge MCLK_IN) disable iff (!RST_N_IN) $rose(REG_WRITE_STROBE_OUT) |=> !REG_WRITE_STROBE_OUT;
  endproperty
  a_reg_pulse: assert property (p_reg_pulse) else $error("write pulse too long");
  property p_busy;
    @(posedge MCLK_IN) disable iff (!RST_N_IN) s_cs_held |-> BUSY_OUT;
  endproperty
  a_busy: assert property (p_busy) else $error("busy missing");
endmodule : psram_link_monitor

bind psram_link_dev psram_link_monitor u_psram_link_monitor (
  .MCLK_IN(MCLK_IN),
  .RST_N_IN(RST_N_IN),
  .LINK_CK_IN(LINK_CK_IN),
  .CS_N_IN(CS_N_IN),
  .DQ_IN(DQ_IN),
  .DQ_OE_N_OUT(DQ_OE_N_OUT),
  .READ_WRITE_STROBE_OUT(READ_WRITE_STROBE_OUT),
  .READ_WRITE_STROBE_OE_N_OUT(READ_WRITE_STROBE_OE_N_OUT),
  .LATENCY_COUNT_IN(LATENCY_COUNT_IN),
  .EXTRA_LATENCY_IN(EXTRA_LATENCY_IN),
  .BUSY_OUT(BUSY_OUT),
  .REG_WRITE_STROBE_OUT(REG_WRITE_STROBE_OUT)
);

// ### test/psram_host_model.sv
/* host model: link clock, chip select, command words, write data and mask.
   assumes the bench resolves the shared strobe and data wires */
module psram_host_model (
  // link outputs
  output logic ck_out,
  output logic cs_n_out,
  output logic [7:0] dq_out,
  output logic stb_out,
  // link inputs
  input wire logic [7:0] dq_in,
  input wire logic dq_oe_n_in,
  input wire logic stb_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] wd [16];
  logic [1:0] wm [16];
  logic [15:0] rd [16];
  logic cmd_stb, drv, stb_val;
  int stb_err;
  // released strobe toggles so a stale level never looks valid
  assign stb_out = drv ? stb_val : ~ck_out;
  initial begin
    {ck_out, cs_n_out, drv, stb_val} = 4'b0100;
    dq_out = 8'h00;
    stb_err = 0;
  end
  // clock only pulsed for config sync
  task automatic pulses();
    repeat (2) begin
      #24 ck_out = 1'b1;
      #24 ck_out = 1'b0;
    end
  endtask : pulses
  // select with clock low, short bursts
  task automatic frame(input logic [47:0] cmd, input int lat, input int n, input logic msk);
    logic [15:0] w;
    int k;
    int j;
    cs_n_out = 1'b0;
    for (int i = 0; i < 3 + lat + n; i++) begin
      k = i - 3 - lat;
      j = (k < 0) ? 0 : k;
      w = (i < 3) ? cmd[47 - 16 * i -: 16] : (cmd[47] ? {2{i[7:0]}} : wd[j]);
      drv = msk && k >= 0;
      stb_val = wm[j][1];
      dq_out = w[15:8];
      #12 ck_out = 1'b1;
      #12 cmd_stb = (i == 1) ? stb_in : cmd_stb;
      if (cmd[47] && k >= 0) begin
        rd[j][15:8] = dq_in;
        stb_err += (stb_in !== 1'b1 || dq_oe_n_in !== 1'b0);
      end
      dq_out = w[7:0];
      stb_val = wm[j][0];
      #12 ck_out = 1'b0;
      #12 if (cmd[47] && k >= 0) begin
        rd[j][7:0] = dq_in;
        stb_err += (stb_in !== 1'b0);
      end
    end
    cs_n_out = 1'b1;
    drv = 1'b0;
    #24;
  endtask : frame
endmodule : psram_host_model

// ### test/psram_link_dev_tb_top.sv
/* top bench: system clock, reset, host model, device and scenarios.
   assumes the host model owns the link clock and stops it between frames */
module psram_link_dev_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import psram_pkg::*;
  logic mclk, rst_n, link_ck, cs_n, dq_oe_n, stb_host, stb_dev, stb_oe_n, stb_wire;
  logic [7:0] dq_host, dq_dev, dq_back;
  logic [LAT_W-1:0] lat;
  logic [BURST_W-1:0] blen;
  logic extra, busy, reg_stb, seen;
  logic [WORD_W-1:0] reg_data;
  int fail_count, tests_run;
  assign stb_wire = stb_oe_n ? stb_host : stb_dev;
  assign dq_back = dq_oe_n ? ~dq_dev : dq_dev;
  psram_link_dev u_psram_link_dev (.MCLK_IN(mclk), .RST_N_IN(rst_n), .LINK_CK_IN(link_ck),
    .CS_N_IN(cs_n), .DQ_IN(dq_host), .DQ_OUT(dq_dev), .DQ_OE_N_OUT(dq_oe_n),
    .READ_WRITE_STROBE_IN(stb_wire), .READ_WRITE_STROBE_OUT(stb_dev),
    .READ_WRITE_STROBE_OE_N_OUT(stb_oe_n), .LATENCY_COUNT_IN(lat), .BURST_LENGTH_IN(blen),
    .EXTRA_LATENCY_IN(extra), .BUSY_OUT(busy), .REG_WRITE_DATA_OUT(reg_data),
    .REG_WRITE_STROBE_OUT(reg_stb));
  psram_host_model u_host (.ck_out(link_ck), .cs_n_out(cs_n), .dq_out(dq_host),
    .stb_out(stb_host), .dq_in(dq_back), .dq_oe_n_in(dq_oe_n), .stb_in(stb_wire));
  function automatic logic [15:0] word_of(input logic [7:0] a);
    return {a, ~a};
  endfunction : word_of
  function automatic logic [47:0] cmd_word(input logic r, input logic s, input logic l,
                                           input logic [7:0] a);
    return {r, s, l, 24'h000000, a[7:3], 13'h0000, a[2:0]};
  endfunction : cmd_word
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic set_cfg(input logic [3:0] l, input logic [1:0] b, input logic e);
    @(posedge mclk);
    #1 {lat, blen, extra} = {l, b, e};
    u_host.pulses();
  endtask : set_cfg
  task automatic t_mem_linear();
    for (int i = 0; i < 12; i++) begin
      u_host.wd[i] = word_of(8'hFE + i[7:0]);
      u_host.wm[i] = 2'b00;
    end
    u_host.frame(cmd_word(1'b0, 1'b0, 1'b1, 8'hFE), 1, 12, 1'b1);
    u_host.frame(cmd_word(1'b1, 1'b0, 1'b1, 8'hFF), 1, 2, 1'b0);
    check("linear last", word_of(8'hFF), u_host.rd[0]);
    check("linear first", word_of(8'h00), u_host.rd[1]);
    check("latency flag", 16'h0000, {15'h0000, u_host.cmd_stb});
  endtask : t_mem_linear
  task automatic t_mem_wrap();
    logic [7:0] a;
    for (int b = 0; b < 4; b++) begin
      set_cfg(4'h1, b[1:0], 1'b0);
      u_host.frame(cmd_word(1'b1, 1'b0, 1'b0, 8'h06), 1, 4, 1'b0);
      for (int i = 0; i < 4; i++) begin
        a = 8'h06 + i[7:0];
        a = (b == 0) ? {5'h00, a[2:0]} : {4'h0, a[3:0]};
        check("wrapped word", word_of(a), u_host.rd[i]);
      end
    end
  endtask : t_mem_wrap
  task automatic t_mem_mask();
    {u_host.wd[0], u_host.wm[0], u_host.wd[1], u_host.wm[1]} = {16'h1234, 2'b10, 16'h5678, 2'b01};
    u_host.frame(cmd_word(1'b0, 1'b0, 1'b1, 8'h07), 1, 2, 1'b1);
    u_host.frame(cmd_word(1'b1, 1'b0, 1'b1, 8'h07), 1, 2, 1'b0);
    check("byte A kept", 16'h0734, u_host.rd[0]);
    check("byte B kept", 16'h56F7, u_host.rd[1]);
    check("read strobe", 16'h0000, u_host.stb_err[15:0]);
  endtask : t_mem_mask
  task automatic t_reg();
    {u_host.wd[0], u_host.wd[1]} = {16'hA5C3, 16'h0F0F};
    fork
      u_host.frame(cmd_word(1'b0, 1'b1, 1'b0, 8'h00), 0, 2, 1'b0);
      for (int i = 0; i < 60 && reg_stb !== 1'b1; i++) begin
        @(posedge mclk);
        #1 seen = reg_stb;
      end
    join
    check("reg pulse", 16'h0001, {15'h0000, seen});
    check("reg word", 16'hA5C3, reg_data);
    set_cfg(4'h2, 2'h2, 1'b1);
    for (int r = 0; r < 2; r++) begin
      u_host.frame(cmd_word(1'b1, 1'b1, 1'b0, r[7:0]), 4, 1, 1'b0);
      check("reg read", r == 0 ? {4'h2, 2'h2, 1'b1, 9'h000} : REG_ID_WORD, u_host.rd[0]);
    end
    check("latency flag", 16'h0001, {15'h0000, u_host.cmd_stb});
    u_host.frame(cmd_word(1'b1, 1'b0, 1'b0, 8'h00), 4, 1, 1'b0);
    check("doubled latency read", word_of(8'h00), u_host.rd[0]);
    check("data released", 16'h0001, {15'h0000, dq_oe_n});
    check("strobe released", 16'h0001, {15'h0000, stb_oe_n});
  endtask : t_reg
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    {rst_n, lat, blen, extra, seen} = {1'b0, 4'h1, 2'h0, 1'b0, 1'b0};
    {fail_count, tests_run} = {32'd0, 32'd0};
    // link pulses with select high settle the link flops during reset
    fork
      u_host.pulses();
      repeat (10) @(posedge mclk);
    join
    #1 rst_n = 1'b1;
    set_cfg(4'h1, 2'h0, 1'b0);
    t_mem_linear();
    t_mem_wrap();
    t_mem_mask();
    t_reg();
    give_verdict();
  end
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
endmodule : psram_link_dev_tb_top
